/* File: logic/orpe_host.sv */
/*
 * orpe_host: controller that reads, programs, verifies and reads the
 * signature of a byte-wide one-time-programmable ROM through its pins.
 * Assumes the ROM pins are synchronous to core_clk, that vpp_prog_en
 * switches the programming supply and signature_trigger_line switches the
 * high voltage onto the signature address line outside this block.
 */
// Function
// - gate may lag select by access minus gate
// - program mode needs supply, select, strobe low
// - programmer drives byte on data pins
// - select per device, gate from read strobe
// - verify: gate, select low, strobe high, supply
`timescale 1ns/1ps
module orpe_host import orpe_pkg::*; #(
	parameter int unsigned PULSE_CYC = PULSE_CYC_DEF // strobe width
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// speed grade of the attached ROM
	input wire logic [1:0] grade_sel,
	// command port
	input wire logic req_valid,
	input wire orpe_op_t req_op,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	// ROM pins
	output logic [ADDR_W-1:0] rom_addr,
	output logic chip_sel_n,
	output logic out_gate_n,
	output logic program_strobe_n,
	output logic vpp_prog_en,
	output logic signature_trigger_line,
	input wire logic [DATA_W-1:0] rom_data_i,
	output logic [DATA_W-1:0] rom_data_o,
	output logic rom_data_oe
);
	// controller states
	typedef enum logic [2:0] {
		ORPE_ST_IDLE, ORPE_ST_PREP, ORPE_ST_CE, ORPE_ST_OE,
		ORPE_ST_PULSE, ORPE_ST_HOLD, ORPE_ST_FLOAT
	} orpe_state_t;

	localparam logic [TMR_W-1:0] PULSE_LEN = TMR_W'(PULSE_CYC);

	orpe_timer_if t ();
	orpe_state_t state, next_state;
	orpe_op_t op, next_op; // operation in progress
	logic next_req_ready, next_rsp_valid;
	logic [DATA_W-1:0] next_rsp_rdata;
	logic [ADDR_W-1:0] next_rom_addr;
	logic next_chip_sel_n, next_out_gate_n, next_program_strobe_n;
	logic next_vpp_prog_en, next_signature_trigger_line;
	logic [DATA_W-1:0] next_rom_data_o;
	logic next_rom_data_oe;
	logic [TMR_W-1:0] acc_cyc, oe_cyc, df_cyc, gap_cyc; // grade timing

	// wait timer
	orpe_timer u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.t(t)
	);

	// per-grade timing; gate lags select by access minus gate delay
	always_comb begin
		case (grade_sel)
			2'h0: begin
				acc_cyc = ACC_CYC_0;
				oe_cyc = OE_CYC_0;
				df_cyc = DF_CYC_0;
			end
			2'h1: begin
				acc_cyc = ACC_CYC_1;
				oe_cyc = OE_CYC_1;
				df_cyc = DF_CYC_1;
			end
			2'h2: begin
				acc_cyc = ACC_CYC_2;
				oe_cyc = OE_CYC_2;
				df_cyc = DF_CYC_2;
			end
			default: begin
				acc_cyc = ACC_CYC_3;
				oe_cyc = OE_CYC_3;
				df_cyc = DF_CYC_3;
			end
		endcase
		gap_cyc = acc_cyc - oe_cyc;
	end

	// next state and pin values
	always_comb begin
		next_state = state;
		next_op = op;
		next_rsp_valid = 1'b0;
		next_rsp_rdata = rsp_rdata;
		next_rom_addr = rom_addr;
		next_chip_sel_n = chip_sel_n;
		next_out_gate_n = out_gate_n;
		next_program_strobe_n = program_strobe_n;
		next_vpp_prog_en = vpp_prog_en;
		next_signature_trigger_line = signature_trigger_line;
		next_rom_data_o = rom_data_o;
		next_rom_data_oe = rom_data_oe;
		t.load = 1'b0;
		t.load_val = ONE_CYC;
		case (state)
			// idle: ROM in standby, supplies at read level
			ORPE_ST_IDLE: begin
				next_chip_sel_n = 1'b1;
				next_vpp_prog_en = 1'b0;
				next_signature_trigger_line = 1'b0;
				// take a command only when ready is shown, not just after reset
				if (req_valid && req_ready) begin
					next_op = req_op;
					next_rom_addr = req_addr;
					next_state = ORPE_ST_PREP;
					t.load = 1'b1;
					t.load_val = ONE_CYC;
					case (req_op)
						ORPE_OP_PROGRAM: begin
							next_vpp_prog_en = 1'b1;
							next_rom_data_o = req_wdata;
							next_rom_data_oe = 1'b1;
							t.load_val = SETUP_CYC;
						end
						ORPE_OP_VERIFY: begin
							next_vpp_prog_en = 1'b1;
							t.load_val = SETUP_CYC;
						end
						ORPE_OP_SIGNATURE: begin
							// only the lowest address line picks the byte
							next_rom_addr = {{(ADDR_W-1){1'b0}}, req_addr[0]};
							next_signature_trigger_line = 1'b1;
							t.load_val = SETUP_CYC;
						end
						default: begin
						end
					endcase
				end
			end
			// supplies and address settled: select the ROM
			ORPE_ST_PREP: begin
				if (t.done) begin
					next_chip_sel_n = 1'b0;
					next_state = ORPE_ST_CE;
					t.load = 1'b1;
					// the timer adds one edge before the gate falls: load one
					// short so the gate lags select by exactly the gap
					t.load_val = (op == ORPE_OP_PROGRAM) ? SETUP_CYC
						: gap_cyc - ONE_CYC;
				end
			end
			// selected: gate for reads, strobe for programming
			ORPE_ST_CE: begin
				if (t.done) begin
					t.load = 1'b1;
					if (op == ORPE_OP_PROGRAM) begin
						next_program_strobe_n = 1'b0;
						next_state = ORPE_ST_PULSE;
						t.load_val = PULSE_LEN;
					end else begin
						next_out_gate_n = 1'b0;
						next_state = ORPE_ST_OE;
						t.load_val = oe_cyc;
					end
				end
			end
			// gate low long enough: take the byte, release
			ORPE_ST_OE: begin
				if (t.done) begin
					next_rsp_rdata = rom_data_i;
					next_out_gate_n = 1'b1;
					next_chip_sel_n = 1'b1;
					next_state = ORPE_ST_FLOAT;
					t.load = 1'b1;
					t.load_val = df_cyc;
				end
			end
			// end of program pulse
			ORPE_ST_PULSE: begin
				if (t.done) begin
					next_program_strobe_n = 1'b1;
					next_state = ORPE_ST_HOLD;
					t.load = 1'b1;
					t.load_val = HOLD_CYC;
				end
			end
			// data held past the strobe, then deselect
			ORPE_ST_HOLD: begin
				if (t.done) begin
					next_rom_data_oe = 1'b0;
					next_chip_sel_n = 1'b1;
					next_state = ORPE_ST_FLOAT;
					t.load = 1'b1;
					t.load_val = df_cyc;
				end
			end
			// bus settles before the next access
			default: begin
				if (t.done) begin
					next_rsp_valid = 1'b1;
					next_vpp_prog_en = 1'b0;
					next_signature_trigger_line = 1'b0;
					next_state = ORPE_ST_IDLE;
				end
			end
		endcase
		next_req_ready = (next_state == ORPE_ST_IDLE);
	end

	// register state and every output
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= ORPE_ST_IDLE;
			op <= ORPE_OP_READ;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= DATA_RST;
			rom_addr <= ADDR_RST;
			chip_sel_n <= 1'b1;
			out_gate_n <= 1'b1;
			program_strobe_n <= 1'b1;
			vpp_prog_en <= 1'b0;
			signature_trigger_line <= 1'b0;
			rom_data_o <= DATA_RST;
			rom_data_oe <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			req_ready <= next_req_ready;
			rsp_valid <= next_rsp_valid;
			rsp_rdata <= next_rsp_rdata;
			rom_addr <= next_rom_addr;
			chip_sel_n <= next_chip_sel_n;
			out_gate_n <= next_out_gate_n;
			program_strobe_n <= next_program_strobe_n;
			vpp_prog_en <= next_vpp_prog_en;
			signature_trigger_line <= next_signature_trigger_line;
			rom_data_o <= next_rom_data_o;
			rom_data_oe <= next_rom_data_oe;
		end
	end

	// helper counters: cycles with select low, cycles with strobe low
	logic [TMR_W-1:0] ce_cnt, next_ce_cnt, pw_cnt, next_pw_cnt;
	always_comb begin
		next_ce_cnt = chip_sel_n ? '0 : ce_cnt + ONE_CYC;
		next_pw_cnt = program_strobe_n ? '0 : pw_cnt + ONE_CYC;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ce_cnt <= '0;
			pw_cnt <= '0;
		end else begin
			ce_cnt <= next_ce_cnt;
			pw_cnt <= next_pw_cnt;
		end
	end

	// named steps of an access
	sequence s_gate_fall;
		$fell(out_gate_n);
	endsequence
	sequence s_strobe_rise;
		$rose(program_strobe_n);
	endsequence

	a_gate_lag_bound: assert property (@(posedge core_clk) disable iff (rst)
		s_gate_fall |-> ce_cnt == gap_cyc)
		else $error("gate lag differs from access minus gate delay");
	a_prog_entry_cond: assert property (@(posedge core_clk) disable iff (rst)
		!program_strobe_n |-> vpp_prog_en && !chip_sel_n)
		else $error("strobe low outside programming conditions");
	a_prog_data_drive: assert property (@(posedge core_clk) disable iff (rst)
		!program_strobe_n |-> rom_data_oe && out_gate_n)
		else $error("programming without driven data");
	a_verify_levels: assert property (@(posedge core_clk) disable iff (rst)
		(!out_gate_n && vpp_prog_en) |-> program_strobe_n && !chip_sel_n)
		else $error("verify levels wrong");
	a_gate_no_clash: assert property (@(posedge core_clk) disable iff (rst)
		!out_gate_n |-> !chip_sel_n && !rom_data_oe)
		else $error("gate low while deselected or driving");
	a_float_wait: assert property (@(posedge core_clk) disable iff (rst)
		$rose(out_gate_n) |-> !rom_data_oe [*6])
		else $error("data driven inside float time");
	a_pulse_width: assert property (@(posedge core_clk) disable iff (rst)
		s_strobe_rise |-> $past(pw_cnt) == PULSE_LEN)
		else $error("program strobe width wrong");
	a_supply_setup: assert property (@(posedge core_clk) disable iff (rst)
		$rose(vpp_prog_en) |-> chip_sel_n [*8])
		else $error("select low too soon after supply rise");
endmodule // orpe_host

/* File: logic/orpe_pkg.sv */
/*
 * orpe_pkg: shared constants and types for the one-time-programmable ROM
 * host controller: pin widths, timing figures per speed grade, the cycle
 * counts derived from them and the operation codes.
 * Assumes a 100 MHz core clock; every wait rounds up to whole cycles.
 */
package orpe_pkg;
	// pin and counter widths
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int TMR_W = 17;
	localparam int GRADE_N = 4;
	// core clock period in ns
	localparam int CLK_NS = 10;
	// address access time per grade, ns
	localparam int ACC_NS_0 = 180;
	localparam int ACC_NS_1 = 200;
	localparam int ACC_NS_2 = 250;
	localparam int ACC_NS_3 = 300;
	// output gate to data delay per grade, ns
	localparam int OE_NS_0 = 65;
	localparam int OE_NS_1 = 75;
	localparam int OE_NS_2 = 100;
	localparam int OE_NS_3 = 120;
	// output float time per grade, ns
	localparam int DF_NS_0 = 55;
	localparam int DF_NS_1 = 55;
	localparam int DF_NS_2 = 60;
	localparam int DF_NS_3 = 105;
	// programming setup and hold, ns
	localparam int SETUP_NS = 2000;
	localparam int HOLD_NS = 2000;
	// program strobe pulse width, ns
	localparam int PULSE_NS = 1000000;
	// derived cycle counts, rounded up
	localparam logic [TMR_W-1:0] ACC_CYC_0 = TMR_W'((ACC_NS_0+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] ACC_CYC_1 = TMR_W'((ACC_NS_1+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] ACC_CYC_2 = TMR_W'((ACC_NS_2+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] ACC_CYC_3 = TMR_W'((ACC_NS_3+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] OE_CYC_0 = TMR_W'((OE_NS_0+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] OE_CYC_1 = TMR_W'((OE_NS_1+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] OE_CYC_2 = TMR_W'((OE_NS_2+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] OE_CYC_3 = TMR_W'((OE_NS_3+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] DF_CYC_0 = TMR_W'((DF_NS_0+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] DF_CYC_1 = TMR_W'((DF_NS_1+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] DF_CYC_2 = TMR_W'((DF_NS_2+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] DF_CYC_3 = TMR_W'((DF_NS_3+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] SETUP_CYC = TMR_W'((SETUP_NS+CLK_NS-1)/CLK_NS);
	localparam logic [TMR_W-1:0] HOLD_CYC = TMR_W'((HOLD_NS+CLK_NS-1)/CLK_NS);
	localparam int PULSE_CYC_DEF = (PULSE_NS+CLK_NS-1)/CLK_NS;
	// one cycle wait
	localparam logic [TMR_W-1:0] ONE_CYC = 17'h00001;
	// reset values of the pins
	localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	// operations offered on the command port
	typedef enum logic [1:0] {
		ORPE_OP_READ,
		ORPE_OP_PROGRAM,
		ORPE_OP_VERIFY,
		ORPE_OP_SIGNATURE
	} orpe_op_t;
endpackage

/* File: logic/orpe_timer_if.sv */
/*
 * orpe_timer_if: carries a load request and its count from the controller
 * to the wait timer, and the timer's done level back.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
interface orpe_timer_if import orpe_pkg::*; ();
	logic load; // start a new wait
	logic [TMR_W-1:0] load_val; // wait length in cycles
	logic done; // wait has run out
	modport ctrl (output load, output load_val, input done);
	modport tmr (input load, input load_val, output done);
endinterface

/* File: logic/orpe_timer.sv */
/*
 * orpe_timer: down counter that measures every wait of the controller.
 * Assumes load_val is at least one; done is low the cycle after a load.
 */
`timescale 1ns/1ps
module orpe_timer import orpe_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// controller side
	orpe_timer_if.tmr t
);
	logic [TMR_W-1:0] cnt; // cycles left
	logic [TMR_W-1:0] next_cnt;

	// next count: load wins, otherwise count down to zero
	always_comb begin
		next_cnt = cnt;
		if (t.load) begin
			next_cnt = t.load_val;
		end else if (cnt != '0) begin
			next_cnt = cnt - ONE_CYC;
		end
	end

	// register the count
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// done while idle; must not look at load, the controller derives load
	// from done and a path back would form a combinational loop
	assign t.done = (cnt == '0);
endmodule // orpe_timer

/* File: testbench/orpe_rom_model.sv */
/*
 * orpe_rom_model: byte-wide one-time-programmable ROM seen from its pins,
 * standing on the far side of the host controller.
 * Assumes the pins change only at core_clk rising edges, and that the
 * testbench resolves the shared data pins into bus.
 */
`timescale 1ns/1ps
module orpe_rom_model import orpe_pkg::*; #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'hC3 // arbitrary value
) (
	// clock and grade
	input wire logic core_clk,
	input wire logic [1:0] grade_sel,
	// controls from the host
	input wire logic [ADDR_W-1:0] addr,
	input wire logic cs_n,
	input wire logic gate_n,
	input wire logic strobe_n,
	input wire logic vpp_hi,
	input wire logic sig_hi,
	input wire logic host_oe,
	// resolved data pins and this device's drive
	input wire logic [DATA_W-1:0] bus,
	output logic [DATA_W-1:0] q,
	output int faults
);
	logic [DATA_W-1:0] mem [0:8191]; // 8192 bytes
	logic [DATA_W-1:0] last; // bus level at the previous edge
	logic [DATA_W-1:0] word; // addressed content
	logic [ADDR_W-1:0] prev_addr; // address at the previous edge
	logic drive; // output drivers on
	logic ready; // access and gate delays have run
	int cs_cnt; // edges selected with a stable address
	int gate_cnt; // edges with the gate low
	int acc_t [0:3] = '{ACC_NS_0, ACC_NS_1, ACC_NS_2, ACC_NS_3};
	int oe_t [0:3] = '{OE_NS_0, OE_NS_1, OE_NS_2, OE_NS_3};
	// signature mode returns a code, else the array
	assign word = sig_hi ? (addr[0] ? PART_CODE : MAKER_CODE) : mem[addr];
	// drivers on only when selected, gated and not programming
	assign drive = !cs_n && !gate_n && strobe_n;
	// data settles after access and gate delays
	assign ready = (cs_cnt + 1) * CLK_NS >= acc_t[grade_sel]
		&& (gate_cnt + 1) * CLK_NS >= oe_t[grade_sel];
	// unsettled or released pins never show a stale value
	assign q = drive ? (ready ? word : ~word) : ~last;
	// erased array reads all ones
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 8'hFF;
		end
	end
	// pin history, contention and programming
	always @(posedge core_clk) begin
		last <= bus;
		prev_addr <= addr;
		// standby or a new address restarts the access
		cs_cnt <= (cs_n || addr != prev_addr) ? 0 : cs_cnt + 1;
		gate_cnt <= gate_n ? 0 : gate_cnt + 1;
		// both sides driving the data pins is a fault
		if (host_oe && drive) begin
			faults <= faults + 1;
		end
		// strobe in program mode clears zero bits
		if (vpp_hi && !cs_n && !strobe_n) begin
			mem[addr] <= mem[addr] & bus;
			// the byte must come from the host
			if (!host_oe) begin
				faults <= faults + 1;
			end
		end
		// signature reads need all other address lines low
		if (sig_hi && !cs_n && addr[ADDR_W-1:1] != '0) begin
			faults <= faults + 1;
		end
	end
endmodule // orpe_rom_model

/* File: testbench/testbench.sv */
/*
 * testbench: drives the ROM host controller through its command port
 * against the ROM model and judges every answer.
 * Assumes the strobe width parameter is shortened to 20 cycles.
 */
`timescale 1ns/1ps
module testbench import orpe_pkg::*; ;
	localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
	localparam logic [7:0] PART = 8'hC3; // arbitrary value
	// host ports
	logic core_clk, rst, req_valid, req_ready, rsp_valid;
	logic chip_sel_n, out_gate_n, program_strobe_n, vpp_prog_en;
	logic signature_trigger_line, rom_data_oe;
	logic [1:0] grade_sel;
	orpe_op_t req_op;
	logic [ADDR_W-1:0] req_addr, rom_addr;
	logic [DATA_W-1:0] req_wdata, rsp_rdata, rom_data_o, rom_data_i, rom_q;
	int err_count, checks_done, faults;
	logic [7:0] r;
	// host drive wins where enabled, else the model's pins
	assign rom_data_i = rom_data_oe ? rom_data_o : rom_q;
	orpe_host #(.PULSE_CYC(20)) orpe_host_inst (.core_clk, .rst,
		.grade_sel, .req_valid, .req_op, .req_addr, .req_wdata, .req_ready,
		.rsp_valid, .rsp_rdata, .rom_addr, .chip_sel_n, .out_gate_n,
		.program_strobe_n, .vpp_prog_en, .signature_trigger_line,
		.rom_data_i, .rom_data_o, .rom_data_oe);
	orpe_rom_model #(.MAKER_CODE(MAKER), .PART_CODE(PART))
		orpe_rom_model_inst (.core_clk, .grade_sel, .addr(rom_addr),
		.cs_n(chip_sel_n), .gate_n(out_gate_n), .strobe_n(program_strobe_n),
		.vpp_hi(vpp_prog_en), .sig_hi(signature_trigger_line),
		.host_oe(rom_data_oe), .bus(rom_data_i), .q(rom_q), .faults);
	// 100 MHz clock
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	// counts, verdict and end of run
	task stop_test;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// byte compare
	task chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h", $time, m, got);
		end
	endtask
	// one command, waits for its answer
	task do_op(input orpe_op_t op, input logic [12:0] a,
		input logic [7:0] d);
		int n;
		@(posedge core_clk);
		req_op <= op;
		req_addr <= a;
		req_wdata <= d;
		req_valid <= 1'b1;
		n = 0;
		@(posedge core_clk);
		while (req_ready !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 50) begin
			err_count++;
			$display("unexpected at %0t: request never taken", $time);
		end
		req_valid <= 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 3000) begin
			err_count++;
			$display("unexpected at %0t: no answer", $time);
		end
		r = rsp_rdata;
		// back in standby with the pins released at the answer
		chk8({6'h00, chip_sel_n, rom_data_oe}, 8'h02, "standby");
	endtask
	// command followed by a byte compare
	task rd_chk(input orpe_op_t op, input logic [12:0] a,
		input logic [7:0] e);
		do_op(op, a, 8'h00);
		chk8(r, e, "read byte");
	endtask
	// pins held quiet during reset
	task t_reset;
		@(posedge core_clk);
		chk8({req_ready, chip_sel_n, out_gate_n, program_strobe_n,
			vpp_prog_en, signature_trigger_line, rom_data_oe, 1'b0},
			8'h70, "reset pins");
	endtask
	// erased reads at every grade and the address ends
	task t_grades;
		for (int g = 0; g < 4; g++) begin
			@(posedge core_clk);
			grade_sel <= 2'(g);
			rd_chk(ORPE_OP_READ, 13'h1FFF, 8'hFF);
			rd_chk(ORPE_OP_READ, 13'h0000, 8'hFF);
		end
	endtask
	// two programs on one byte only clear bits
	task t_program;
		do_op(ORPE_OP_PROGRAM, 13'h1FFF, 8'hA5);
		rd_chk(ORPE_OP_READ, 13'h1FFF, 8'hA5);
		do_op(ORPE_OP_PROGRAM, 13'h1FFF, 8'h3C);
		rd_chk(ORPE_OP_VERIFY, 13'h1FFF, 8'h24);
		rd_chk(ORPE_OP_READ, 13'h1FFE, 8'hFF);
	endtask
	// both signature bytes
	task t_signature;
		rd_chk(ORPE_OP_SIGNATURE, 13'h1FFE, MAKER);
		rd_chk(ORPE_OP_SIGNATURE, 13'h1FFF, PART);
	endtask
	// a program request while busy must be dropped
	task t_refuse;
		fork
			do_op(ORPE_OP_READ, 13'h0005, 8'h00);
			begin
				repeat (4) @(posedge core_clk);
				req_op <= ORPE_OP_PROGRAM;
				req_wdata <= 8'h00;
				req_valid <= 1'b1;
				repeat (5) @(posedge core_clk);
				req_valid <= 1'b0;
			end
		join
		chk8(r, 8'hFF, "busy read");
		rd_chk(ORPE_OP_READ, 13'h0005, 8'hFF);
	endtask
	// main sequence
	initial begin
		err_count = 0;
		checks_done = 0;
		rst = 1'b1;
		req_valid = 1'b0;
		req_op = ORPE_OP_READ;
		req_addr = 13'h0000;
		req_wdata = 8'h00;
		grade_sel = 2'h0;
		repeat (19) @(posedge core_clk);
		t_reset;
		rst <= 1'b0;
		t_grades;
		t_program;
		t_signature;
		t_refuse;
		chk8(8'(faults), 8'h00, "pin faults");
		stop_test;
	end
	// cut a hang short
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		$display("unexpected at %0t: watchdog ran out", $time);
		stop_test;
	end
endmodule // testbench
